//--- rtl/vdss_top.sv
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`include "vdss_cfg.svh"

module vdss_top #(
  parameter int unsigned NET_TIMEOUT_CYC = `VDSS_NET_TIMEOUT_CYC,
  parameter int unsigned POS_ERR_CYC     = `VDSS_POS_ERR_CYC,
  parameter int unsigned CLOSE_TMO_CYC   = `VDSS_CLOSE_TMO_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic [15:0] i_analog_ua,
  input  wire logic [13:0] i_pos_meas,
  input  wire logic        i_sd_closed,
  input  wire logic        i_net_msg_bad,
  input  wire logic        i_net_dup_id,
  input  wire logic        i_net_bus_off,
  output logic [13:0]      o_pos_target,
  output logic             o_loop_en,
  output logic             o_cur_close,
  output logic             o_pwm_drive,
  output logic [15:0]      o_fb_ua,
  output logic             o_status_closed,
  output logic             o_src_analog,
  output logic [1:0]       o_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0]  pin_s;
  logic        sd_prev_r;
  logic        sd_closed;
  logic        sd_close_evt;

  // contact bit resets closed so that a contact already closed at power-up is no reset
  vdss_sync #(.W(4), .RST(4'h8)) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_sd_closed, i_net_msg_bad, i_net_dup_id, i_net_bus_off}),
    .o_q   (pin_s)
  );

  assign sd_closed    = pin_s[3];
  assign sd_close_evt = sd_closed & ~sd_prev_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sd_prev_r <= 1'b1;
    end else begin
      sd_prev_r <= sd_closed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and axi4-lite slave
  logic                aw_rdy_r;
  logic                w_rdy_r;
  logic                b_vld_r;
  logic [1:0]          b_resp_r;
  logic [7:0]          awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                ar_rdy_r;
  logic                r_vld_r;
  logic [1:0]          r_resp_r;
  logic [31:0]         rdata_r;
  logic [31:0]         rd_mux;
  logic                rd_hit;
  logic                wr_go;
  logic [2:0]          ctrl_r;
  vdss_pkg::vdss_pos_t net_demand_r;
  vdss_pkg::vdss_pos_t limit_r;
  logic [31:0]         net_wr_val;
  logic [31:0]         lim_wr_val;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // both halves of a write are held until the response is taken, so one write at a time
  assign wr_go      = ~aw_rdy_r & ~w_rdy_r & ~b_vld_r;
  assign net_wr_val = merge({18'h0, net_demand_r}, wdata_r, wstrb_r);
  assign lim_wr_val = merge({18'h0, limit_r}, wdata_r, wstrb_r);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_rdy_r <= 1'b1;
      w_rdy_r  <= 1'b1;
      b_vld_r  <= 1'b0;
      b_resp_r <= `VDSS_RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end else begin
      if (i_s_axi_awvalid && aw_rdy_r) begin
        aw_rdy_r <= 1'b0;
        awaddr_r <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && w_rdy_r) begin
        w_rdy_r <= 1'b0;
        wdata_r <= i_s_axi_wdata;
        wstrb_r <= i_s_axi_wstrb;
      end
      if (wr_go) begin
        b_vld_r  <= 1'b1;
        b_resp_r <= (awaddr_r == `VDSS_ADDR_CTRL || awaddr_r == `VDSS_ADDR_NET_DEMAND ||
                     awaddr_r == `VDSS_ADDR_MISMATCH_LIM) ? `VDSS_RESP_OKAY : `VDSS_RESP_DECERR;
      end
      if (b_vld_r && i_s_axi_bready) begin
        b_vld_r  <= 1'b0;
        aw_rdy_r <= 1'b1;
        w_rdy_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r  <= `VDSS_CTRL_RST;
      limit_r <= `VDSS_MISMATCH_RST;
    end else if (wr_go && awaddr_r == `VDSS_ADDR_CTRL && wstrb_r[0]) begin
      ctrl_r  <= wdata_r[2:0];
    end else if (wr_go && awaddr_r == `VDSS_ADDR_MISMATCH_LIM) begin
      limit_r <= lim_wr_val[13:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // network demand and its fault
  logic        net_seen_r;
  logic        net_bad_r;
  logic [31:0] net_age_r;
  logic        net_fault_r;
  logic        net_wr;

  assign net_wr = wr_go && awaddr_r == `VDSS_ADDR_NET_DEMAND;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      net_demand_r <= 14'h0;
      net_seen_r   <= 1'b0;
      net_bad_r    <= 1'b0;
      net_age_r    <= 32'h0;
    end else if (net_wr) begin
      net_age_r  <= 32'h0;
      net_seen_r <= 1'b1;
      // an empty or out-of-range message flags a fault and keeps the last good demand
      if (wstrb_r == 4'h0 || net_wr_val > 32'(`VDSS_POS_FULL)) begin
        net_bad_r <= 1'b1;
      end else begin
        net_bad_r    <= 1'b0;
        net_demand_r <= net_wr_val[13:0];
      end
    end else if (net_age_r < NET_TIMEOUT_CYC) begin
      net_age_r <= net_age_r + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      net_fault_r <= 1'b1;
    end else begin
      net_fault_r <= net_bad_r | pin_s[2] | pin_s[1] | pin_s[0] |
                     ~net_seen_r | (net_age_r >= NET_TIMEOUT_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog demand and source selection
  logic                analog_fault;
  vdss_pkg::vdss_pos_t analog_pos;
  logic [16:0]         an_scaled;
  vdss_sel_if          sel_if ();

  assign analog_fault = i_analog_ua < `VDSS_UA_LOW_FAULT || i_analog_ua > `VDSS_UA_HIGH_FAULT;
  assign an_scaled    = 17'(i_analog_ua - `VDSS_UA_ZERO) * 17'h5;

  always_comb begin
    if (i_analog_ua <= `VDSS_UA_ZERO) begin
      analog_pos = 14'h0;
    end else if (i_analog_ua >= `VDSS_UA_FULL) begin
      analog_pos = `VDSS_POS_FULL;
    end else begin
      analog_pos = 14'(an_scaled >> 3);
    end
  end

  assign sel_if.backup_en    = ctrl_r[`VDSS_CTRL_BACKUP_EN];
  assign sel_if.analog_pref  = ctrl_r[`VDSS_CTRL_ANALOG_PREF];
  assign sel_if.analog_only  = ctrl_r[`VDSS_CTRL_ANALOG_ONLY];
  assign sel_if.net_fault    = net_fault_r;
  assign sel_if.analog_fault = analog_fault;
  assign sel_if.net_pos      = net_demand_r;
  assign sel_if.analog_pos   = analog_pos;
  assign sel_if.limit        = limit_r;

  vdss_src_sel u_sel (
    .s (sel_if.sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode supervisor
  vdss_pkg::vdss_mode_t mode_r;
  vdss_pkg::vdss_pos_t  target_r;
  vdss_pkg::vdss_pos_t  pos_diff;
  logic [31:0]          err_cnt_r;
  logic [31:0]          close_cnt_r;

  assign pos_diff = (i_pos_meas > target_r) ? 14'(i_pos_meas - target_r) : 14'(target_r - i_pos_meas);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_r <= vdss_pkg::VDSS_SHUTDOWN;
    end else begin
      case (mode_r)
        vdss_pkg::VDSS_RUNNING: begin
          if (!sd_closed || sel_if.src_fail) begin
            mode_r <= vdss_pkg::VDSS_SHUTDOWN;
          end else if (err_cnt_r >= POS_ERR_CYC) begin
            mode_r <= vdss_pkg::VDSS_CLOSE_CUR;
          end
        end
        vdss_pkg::VDSS_SHUTDOWN: begin
          if (sd_close_evt) begin
            mode_r <= vdss_pkg::VDSS_RUNNING;
          end
        end
        vdss_pkg::VDSS_CLOSE_CUR: begin
          if (sd_close_evt) begin
            mode_r <= vdss_pkg::VDSS_RUNNING;
          end else if (close_cnt_r >= CLOSE_TMO_CYC) begin
            mode_r <= vdss_pkg::VDSS_CLOSE_PWM;
          end
        end
        vdss_pkg::VDSS_CLOSE_PWM: begin
          if (sd_close_evt) begin
            mode_r <= vdss_pkg::VDSS_RUNNING;
          end
        end
        default: begin
          mode_r <= vdss_pkg::VDSS_SHUTDOWN;
        end
      endcase
    end
  end

  // persistence filter, so servo lag on a demand step is not taken as a jam
  always_ff @(posedge i_clk) begin
    if (i_rst || mode_r != vdss_pkg::VDSS_RUNNING || pos_diff <= `VDSS_POS_ERR_LIM) begin
      err_cnt_r <= 32'h0;
    end else if (err_cnt_r < POS_ERR_CYC) begin
      err_cnt_r <= err_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || mode_r != vdss_pkg::VDSS_CLOSE_CUR || i_pos_meas <= `VDSS_POS_CLOSED_LIM) begin
      close_cnt_r <= 32'h0;
    end else if (close_cnt_r < CLOSE_TMO_CYC) begin
      close_cnt_r <= close_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm close drive
  logic [7:0] tick_cnt_r;
  logic       tick;
  logic [7:0] pwm_cnt_r;

  assign tick = tick_cnt_r == `VDSS_PWM_TICK_CYC - 8'h1;

  always_ff @(posedge i_clk) begin
    if (i_rst || tick) begin
      tick_cnt_r <= 8'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pwm_cnt_r <= 8'h0;
    end else if (tick) begin
      pwm_cnt_r <= pwm_cnt_r + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic        loop_en_r;
  logic        cur_close_r;
  logic        pwm_drive_r;
  logic [15:0] fb_ua_r;
  logic        status_r;
  logic        src_an_r;
  logic [16:0] fb_scaled;
  logic        run;

  assign run       = mode_r == vdss_pkg::VDSS_RUNNING;
  assign fb_scaled = (17'(i_pos_meas) << 3) / 17'h5;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      target_r    <= 14'h0;
      loop_en_r   <= 1'b1;
      cur_close_r <= 1'b0;
      pwm_drive_r <= 1'b0;
      fb_ua_r     <= 16'h0;
      status_r    <= 1'b0;
      src_an_r    <= 1'b0;
    end else begin
      target_r    <= run ? (sel_if.use_analog ? analog_pos : net_demand_r) : 14'h0;
      loop_en_r   <= run || mode_r == vdss_pkg::VDSS_SHUTDOWN;
      cur_close_r <= mode_r == vdss_pkg::VDSS_CLOSE_CUR;
      pwm_drive_r <= mode_r == vdss_pkg::VDSS_CLOSE_PWM && pwm_cnt_r < `VDSS_PWM_DUTY;
      fb_ua_r     <= run ? 16'(`VDSS_UA_ZERO + fb_scaled) : 16'h0;
      status_r    <= run;
      src_an_r    <= run && sel_if.use_analog;
    end
  end

  assign o_pos_target    = target_r;
  assign o_loop_en       = loop_en_r;
  assign o_cur_close     = cur_close_r;
  assign o_pwm_drive     = pwm_drive_r;
  assign o_fb_ua         = fb_ua_r;
  assign o_status_closed = status_r;
  assign o_src_analog    = src_an_r;

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rd_hit = 1'b1;
    case (i_s_axi_araddr)
      `VDSS_ADDR_CTRL:         rd_mux = {29'h0, ctrl_r};
      `VDSS_ADDR_NET_DEMAND:   rd_mux = {18'h0, net_demand_r};
      `VDSS_ADDR_MISMATCH_LIM: rd_mux = {18'h0, limit_r};
      `VDSS_ADDR_STATUS:       rd_mux = {24'h0, sd_closed, net_bad_r, sel_if.mismatch, analog_fault,
                                         net_fault_r, sel_if.use_analog, mode_r};
      `VDSS_ADDR_ANALOG_POS:   rd_mux = {18'h0, analog_pos};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ar_rdy_r <= 1'b1;
      r_vld_r  <= 1'b0;
      r_resp_r <= `VDSS_RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (i_s_axi_arvalid && ar_rdy_r) begin
      ar_rdy_r <= 1'b0;
      r_vld_r  <= 1'b1;
      rdata_r  <= rd_mux;
      r_resp_r <= rd_hit ? `VDSS_RESP_OKAY : `VDSS_RESP_DECERR;
    end else if (r_vld_r && i_s_axi_rready) begin
      ar_rdy_r <= 1'b1;
      r_vld_r  <= 1'b0;
    end
  end

  assign o_s_axi_awready = aw_rdy_r;
  assign o_s_axi_wready  = w_rdy_r;
  assign o_s_axi_bvalid  = b_vld_r;
  assign o_s_axi_bresp   = b_resp_r;
  assign o_s_axi_arready = ar_rdy_r;
  assign o_s_axi_rvalid  = r_vld_r;
  assign o_s_axi_rresp   = r_resp_r;
  assign o_s_axi_rdata   = rdata_r;
  assign o_mode          = mode_r;

endmodule

//--- rtl/vdss_cfg.svh
`ifndef VDSS_CFG_SVH
`define VDSS_CFG_SVH

// clock and timing
`define VDSS_CLK_MHZ           200
`define VDSS_NET_TIMEOUT_MS    100
`define VDSS_NET_TIMEOUT_CYC   (`VDSS_NET_TIMEOUT_MS * 1000 * `VDSS_CLK_MHZ)
`define VDSS_POS_ERR_US        500
`define VDSS_POS_ERR_CYC       (`VDSS_POS_ERR_US * `VDSS_CLK_MHZ)
`define VDSS_CLOSE_TMO_MS      200
`define VDSS_CLOSE_TMO_CYC     (`VDSS_CLOSE_TMO_MS * 1000 * `VDSS_CLK_MHZ)
`define VDSS_PWM_TICK_CYC      8'hc8
`define VDSS_PWM_DUTY          8'hc0

// analog scaling, currents in microamps, positions in 0.01 % steps
`define VDSS_UA_ZERO           16'h0fa0
`define VDSS_UA_FULL           16'h4e20
`define VDSS_UA_LOW_FAULT      16'h07d0
`define VDSS_UA_HIGH_FAULT     16'h55f0
`define VDSS_POS_FULL          14'h2710
`define VDSS_POS_ERR_LIM       14'h00c8
`define VDSS_POS_CLOSED_LIM    14'h0032

// register map, byte addresses
`define VDSS_ADDR_CTRL         8'h00
`define VDSS_ADDR_NET_DEMAND   8'h04
`define VDSS_ADDR_MISMATCH_LIM 8'h08
`define VDSS_ADDR_STATUS       8'h0c
`define VDSS_ADDR_ANALOG_POS   8'h10

// field positions and reset values
`define VDSS_CTRL_BACKUP_EN    0
`define VDSS_CTRL_ANALOG_PREF  1
`define VDSS_CTRL_ANALOG_ONLY  2
`define VDSS_CTRL_RST          3'h0
`define VDSS_MISMATCH_RST      14'h0064
`define VDSS_RESP_OKAY         2'h0
`define VDSS_RESP_DECERR       2'h3

`endif

//--- rtl/vdss_pkg.sv
package vdss_pkg;
  typedef enum logic [1:0] {
    VDSS_RUNNING,
    VDSS_SHUTDOWN,
    VDSS_CLOSE_CUR,
    VDSS_CLOSE_PWM
  } vdss_mode_t;

  typedef logic [13:0] vdss_pos_t;
endpackage

//--- rtl/vdss_sel_if.sv
interface vdss_sel_if;
  logic               backup_en;
  logic               analog_pref;
  logic               analog_only;
  logic               net_fault;
  logic               analog_fault;
  vdss_pkg::vdss_pos_t net_pos;
  vdss_pkg::vdss_pos_t analog_pos;
  vdss_pkg::vdss_pos_t limit;
  logic               use_analog;
  logic               src_fail;
  logic               mismatch;

  modport ctl (output backup_en, analog_pref, analog_only, net_fault, analog_fault, net_pos, analog_pos, limit,
               input use_analog, src_fail, mismatch);
  modport sel (input backup_en, analog_pref, analog_only, net_fault, analog_fault, net_pos, analog_pos, limit,
               output use_analog, src_fail, mismatch);
endinterface

//--- rtl/vdss_sync.sv
module vdss_sync #(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= RST;
      q_r    <= RST;
    end else begin
      meta_r <= i_d;
      q_r    <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule

//--- rtl/vdss_src_sel.sv
module vdss_src_sel (
  vdss_sel_if.sel s
);
  logic [13:0] diff;

  always_comb begin
    diff = (s.net_pos > s.analog_pos) ? 14'(s.net_pos - s.analog_pos) : 14'(s.analog_pos - s.net_pos);
    s.mismatch   = diff > s.limit;
    s.use_analog = 1'b0;
    s.src_fail   = 1'b0;
    if (s.analog_only) begin
      s.use_analog = 1'b1;
      s.src_fail   = s.analog_fault;
    end else if (!s.backup_en) begin
      s.src_fail   = s.net_fault;
    end else if (s.net_fault && s.analog_fault) begin
      s.src_fail   = 1'b1;
    end else if (s.net_fault) begin
      s.use_analog = 1'b1;
    end else if (!s.analog_fault && !s.mismatch) begin
      s.use_analog = s.analog_pref;
    end
  end
endmodule

//--- tb/vdss_monitor.sv
module vdss_monitor (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_sd_closed,
  input wire logic [13:0] i_pos_meas,
  input wire logic [13:0] o_pos_target,
  input wire logic        o_loop_en,
  input wire logic        o_cur_close,
  input wire logic        o_pwm_drive,
  input wire logic [15:0] o_fb_ua,
  input wire logic        o_status_closed,
  input wire logic        o_src_analog,
  input wire logic [1:0]  o_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  AST_FB_ZERO: assert property (o_mode != 2'h0 |=> o_fb_ua == 16'h0)
    else $error("feedback not zero while shut down");
  AST_STATUS: assert property (o_status_closed == ($past(o_mode) == 2'h0))
    else $error("status contact does not follow mode");
  AST_TARGET_ZERO: assert property ($past(o_mode) == 2'h1 |-> o_pos_target == 14'h0)
    else $error("target not zero in shutdown");
  AST_LOOP: assert property (o_loop_en == !$past(o_mode[1]))
    else $error("loop enable wrong for mode");
  AST_CUR: assert property (o_cur_close == ($past(o_mode) == 2'h2))
    else $error("current close wrong for mode");
  AST_PWM: assert property (o_pwm_drive |-> $past(o_mode) == 2'h3)
    else $error("pwm drive outside pwm mode");
  AST_SD_OPEN: assert property (!i_sd_closed [*5] |-> o_mode != 2'h0)
    else $error("running with contact open");
  AST_RESUME: assert property ($rose(o_mode == 2'h0) |-> $past(i_sd_closed) &&
    (!$past(i_sd_closed, 4) || !$past(i_sd_closed, 5) || !$past(i_sd_closed, 6)))
    else $error("running without contact reset");
  AST_FB_RUN: assert property ((o_mode == 2'h0 && $stable(i_pos_meas)) [*3] |=>
    o_fb_ua == 16'(32'h0fa0 + 32'($past(i_pos_meas)) * 8 / 5))
    else $error("feedback not scaled from position");
  COV_RUN: cover property (o_mode == 2'h0 ##1 o_status_closed);
  COV_PWM: cover property (o_mode == 2'h3 ##1 o_pwm_drive);
  COV_ANALOG: cover property (o_src_analog && o_mode == 2'h0);
endmodule

bind vdss_top vdss_monitor u_vdss_monitor (.i_clk(i_clk), .i_rst(i_rst), .i_sd_closed(i_sd_closed),
  .i_pos_meas(i_pos_meas), .o_pos_target(o_pos_target), .o_loop_en(o_loop_en), .o_cur_close(o_cur_close),
  .o_pwm_drive(o_pwm_drive), .o_fb_ua(o_fb_ua), .o_status_closed(o_status_closed),
  .o_src_analog(o_src_analog), .o_mode(o_mode));

//--- tb/vdss_ecs_model.sv
module vdss_ecs_model (
  input  wire logic        i_clk,
  input  wire logic        i_open,
  input  wire logic [15:0] i_ua,
  output logic             o_sd_closed,
  output logic [15:0]      o_analog_ua
);
  timeunit 1ns;
  timeprecision 1ps;
  // contact held closed for normal running; opening it is the only way to reset
  always @(posedge i_clk) o_sd_closed <= !i_open;
  // demand current in microamps, 4 mA closed to 20 mA open
  always @(posedge i_clk) o_analog_ua <= i_ua;
endmodule

//--- tb/test_valve_demand_select_shutdown.sv
`include "vdss_cfg.svh"
module test_valve_demand_select_shutdown;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 0, i_rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic        awready, wready, bvalid, arready, rvalid, loop_en, cur_close, pwm, st, src_a, sd, trk = 1;
  logic        open_cmd = 0, bad = 0, dup = 0, boff = 0;
  logic [3:0]  strb = 4'hf;
  logic [13:0] p_tab [3] = '{14'h0, 14'h2710, 14'h0};
  logic [15:0] u_tab [2] = '{16'h07cf, 16'h55f1};
  logic [1:0]  bresp, rresp, mode, r;
  logic [13:0] meas = 0, meas_off = 0, tgt, a;
  logic [15:0] fb, ua, ua_cmd = 16'h2ee0;
  int          bad_count = 0, compares = 0, p;
  initial forever #2.5 i_clk = !i_clk;
  always @(posedge i_clk) meas <= trk ? tgt : meas_off;
  vdss_ecs_model u_vdss_ecs_model (.i_clk(i_clk), .i_open(open_cmd), .i_ua(ua_cmd), .o_sd_closed(sd),
    .o_analog_ua(ua));
  vdss_top #(.NET_TIMEOUT_CYC(3000), .POS_ERR_CYC(20), .CLOSE_TMO_CYC(30)) u_vdss_top (
    .i_clk(i_clk), .i_rst(i_rst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(strb), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_analog_ua(ua),
    .i_pos_meas(meas), .i_sd_closed(sd), .i_net_msg_bad(bad), .i_net_dup_id(dup), .i_net_bus_off(boff),
    .o_pos_target(tgt), .o_loop_en(loop_en), .o_cur_close(cur_close), .o_pwm_drive(pwm), .o_fb_ua(fb),
    .o_status_closed(st), .o_src_analog(src_a), .o_mode(mode));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [13:0] apos(input logic [15:0] u);
    if (u <= 16'h0fa0) return 14'h0;
    if (u >= 16'h4e20) return 14'h2710;
    return 14'((32'(u) - 32'h0fa0) * 5 / 8);
  endfunction
  function automatic logic [15:0] fbx(input logic [13:0] q);
    return 16'(32'h0fa0 + 32'(q) * 8 / 5);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // slave ready/valid sampled at the falling edge, so the rising edge never races the design
  task automatic wr(input logic [7:0] ad, input logic [31:0] v, output logic [1:0] rsp);
    logic ta, tw, tb;
    @(posedge i_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {ad, v, 3'h7};
    do begin
      @(negedge i_clk);
      {ta, tw, tb, rsp} = {awready, wready, bvalid, bresp};
      @(posedge i_clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) bready <= 0;
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] v, output logic [1:0] rsp);
    logic ta, tr;
    @(posedge i_clk);
    {araddr, arvalid, rready} <= {ad, 2'h3};
    do begin
      @(negedge i_clk);
      {ta, tr, v, rsp} = {arready, rvalid, rdata, rresp};
      @(posedge i_clk);
      if (ta) arvalid <= 0;
      if (tr) rready <= 0;
    end while (!tr);
  endtask
  task automatic net(input logic [13:0] v);
    wr(`VDSS_ADDR_NET_DEMAND, 32'(v), r);
    chk(r, `VDSS_RESP_OKAY);
    repeat (5) @(negedge i_clk);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    for (int n = 0; n < 80 && mode !== m; n++) @(negedge i_clk);
    repeat (3) @(negedge i_clk);
    chk(mode, m);
  endtask
  task automatic restart;
    @(posedge i_clk) open_cmd <= 1;
    repeat (5) @(posedge i_clk);
    open_cmd <= 0;
    wait_mode(2'h0);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    p = $urandom(89);
    repeat (8) @(posedge i_clk);
    i_rst <= 0;
    rd(`VDSS_ADDR_MISMATCH_LIM, d, r);
    chk(d, 32'h64);
    wait_mode(2'h1);
    chk({fb, st, loop_en, tgt}, 32'h4000);
    $display("test power_up done");
    foreach (p_tab[i]) begin
      a = p_tab[i] == 0 ? 14'($urandom % 10001) : p_tab[i];
      net(a);
      if (i == 0) restart;
      chk({tgt, src_a, st}, {a, 2'h1});
      chk(fb, fbx(a));
    end
    $display("test network_follow done");
    for (int f = 0; f < 6; f++) begin
      @(posedge i_clk) {bad, dup, boff, strb} <= {3'(1 << f), f == 5 ? 4'h0 : 4'hf};
      if (f == 3 || f == 5) wr(`VDSS_ADDR_NET_DEMAND, f == 3 ? 32'h2711 : 32'h0, r);
      if (f == 4) repeat (3100) @(posedge i_clk);
      wait_mode(2'h1);
      chk({fb, st, tgt}, 0);
      // fault pins must be gone before the restart, or the valve drops straight back
      @(posedge i_clk) {bad, dup, boff, strb} <= 7'hf;
      net(14'h1388);
      restart;
    end
    $display("test network_faults done");
    wr(`VDSS_ADDR_CTRL, 32'h3, r);
    ua_cmd <= 16'(16'h1f40 + $urandom % 16'h1f41);
    repeat (4) @(negedge i_clk);
    a = apos(ua_cmd);
    for (int k = 0; k < 3; k++) begin
      net(a + 14'(k * 50 + (k / 2) * 50));
      chk({tgt, src_a}, k == 2 ? {a + 14'd150, 1'b0} : {a, 1'b1});
    end
    wr(`VDSS_ADDR_CTRL, 32'h1, r);
    net(a);
    rd(`VDSS_ADDR_CTRL, d, r);
    chk({d[2:0], src_a, tgt}, {4'h2, a});
    $display("test backup_select done");
    @(posedge i_clk) boff <= 1;
    repeat (6) @(negedge i_clk);
    chk({mode, src_a, tgt}, {3'h1, a});
    foreach (u_tab[i]) begin
      @(posedge i_clk) ua_cmd <= u_tab[i];
      wait_mode(2'h1);
      chk({fb, tgt}, 0);
      @(posedge i_clk) ua_cmd <= 16'h07d0;
      restart;
      chk(tgt, 0);
    end
    @(posedge i_clk) boff <= 0;
    $display("test analog_faults done");
    net(14'h1388);
    @(posedge i_clk) open_cmd <= 1;
    wait_mode(2'h1);
    chk({st, fb, tgt}, 0);
    restart;
    {meas_off, trk} <= {14'h14b4, 1'b0};
    wait_mode(2'h2);
    chk({cur_close, loop_en, fb, st}, 32'h40000);
    wait_mode(2'h3);
    // run is far shorter than the high part of the pwm period, so the drive is still on
    chk({cur_close, loop_en, fb, st, pwm}, 32'h1);
    trk <= 1;
    restart;
    $display("test close_modes done");
    wr(`VDSS_ADDR_CTRL, 32'h4, r);
    @(posedge i_clk) ua_cmd <= 16'h4e20;
    repeat (4) @(negedge i_clk);
    chk({mode, src_a, tgt}, {3'h1, 14'h2710});
    rd(`VDSS_ADDR_STATUS, d, r);
    chk({d[7], d[1:0], r}, {3'h4, `VDSS_RESP_OKAY});
    rd(8'h14, d, r);
    chk({d, r}, {32'h0, `VDSS_RESP_DECERR});
    wr(`VDSS_ADDR_STATUS, 32'h0, r);
    chk(r, `VDSS_RESP_DECERR);
    $display("test registers done");
    final_report;
  end
endmodule
